// ### design/tls_analog_filter.sv
/*
 * First-order low-pass filter on the magnitude of the analog limit input.
 * Assumes samples synchronous to clk_sys; time constant in 0.01 ms units.
 */
`timescale 1ns/100ps
`default_nettype none

module tls_analog_filter #(
    parameter int unsigned ADC_W = tls_pkg::ADC_W
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [ADC_W-1:0]  sampleMag,
    input  wire logic [15:0]       timeConst,
    output logic      [ADC_W-1:0]  filtered
);

    localparam int unsigned ACC_W = ADC_W + 16;

    logic [ACC_W-1:0] accReg,   accNext;
    logic [7:0]       tickReg,  tickNext;
    logic [ACC_W-1:0] diffUp;
    logic [ACC_W-1:0] diffDn;

    ////////////////////////////////////////////////////////////////////////
    // Accumulator holds value scaled by timeConst+1; one step per 0.01 ms
    always_comb begin
        diffUp   = '0;
        diffDn   = '0;
        accNext  = accReg;
        tickNext = tickReg + 8'h01;
        if (timeConst == 16'h0000) begin
            accNext  = {16'h0000, sampleMag};                  // No filtering
            tickNext = 8'h00;
        end else if (tickReg >= 8'(tls_pkg::FILT_UNIT_CYC - 1)) begin
            tickNext = 8'h00;
            // acc += sample - acc/(tc+1)
            diffUp  = {16'h0000, sampleMag};
            diffDn  = accReg / ({16'h0000, timeConst} + ACC_W'(1));
            accNext = accReg + diffUp - diffDn;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accReg  <= '0;
            tickReg <= 8'h00;
        end else begin
            accReg  <= accNext;
            tickReg <= tickNext;
        end
    end

    // Scale the accumulator back to the sample range
    assign filtered = (timeConst == 16'h0000) ? sampleMag
                    : ADC_W'(accReg / ({16'h0000, timeConst} + ACC_W'(1)));

endmodule : tls_analog_filter

`default_nettype wire

// ### design/tls_pkg.sv
/*
 * Package for the torque limit selector: setting widths, defaults,
 * ranges and timing constants.
 * Assumes a 10 MHz system clock; settings are plain ports held by the host.
 */
package tls_pkg;

    // Width of every percent-of-rated-torque value
    localparam int unsigned LIM_W             = 10;
    // Internal limits: 0..800 %, default 800 %
    localparam logic [9:0]  INT_LIMIT_MAX     = 10'h320;
    localparam logic [9:0]  INT_LIMIT_DEFAULT = 10'h320;
    // External limits: 0..800 %, default 100 %
    localparam logic [9:0]  EXT_LIMIT_DEFAULT = 10'h064;
    // Analog gain in 0.1 V per rated torque: 10..100, default 30
    localparam logic [6:0]  GAIN_MIN          = 7'h0A;
    localparam logic [6:0]  GAIN_MAX          = 7'h64;
    localparam logic [6:0]  GAIN_DEFAULT      = 7'h1E;
    // Filter time constant unit 0.01 ms, as ns, and cycles per unit
    localparam int unsigned CLK_PERIOD_NS     = 100;
    localparam int unsigned FILT_UNIT_NS      = 10000;
    localparam int unsigned FILT_UNIT_CYC     = FILT_UNIT_NS / CLK_PERIOD_NS;
    // Analog sample: signed millivolts
    localparam int unsigned ADC_W             = 16;
    // Mode selector digit value for analog limiting
    localparam logic [3:0]  APP_ANALOG_LIMIT  = 4'h1;
    // Control modes
    typedef enum logic [1:0] {
        TLS_MODE_SPEED,
        TLS_MODE_POSITION,
        TLS_MODE_TORQUE
    } tls_ctrl_mode_e;

endpackage : tls_pkg

// ### design/tls_torque_limit_selector.sv
/*
 * Torque limit selector: works out forward and reverse torque limits from
 * internal settings, external settings gated by host inputs, and an analog
 * limit, then caps them at the motor's maximum torque.
 * Assumes all settings are synchronous to clk_sys and held by the host; the
 * contact inputs pass through synchronisers; the analog sample arrives as signed millivolts.
 */
`timescale 1ns/100ps
`default_nettype none

module tls_torque_limit_selector #(
    parameter int unsigned LIM_W = tls_pkg::LIM_W,
    parameter int unsigned ADC_W = tls_pkg::ADC_W
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Host contact inputs, active low (closed = 0)
    input  wire logic              fwdExtLimitIn_n,
    input  wire logic              revExtLimitIn_n,
    // Settings
    input  wire logic [LIM_W-1:0]  fwdInternalLimit,
    input  wire logic [LIM_W-1:0]  revInternalLimit,
    input  wire logic [LIM_W-1:0]  fwdExternalLimit,
    input  wire logic [LIM_W-1:0]  revExternalLimit,
    input  wire logic [6:0]        analogRefGain,
    input  wire logic [15:0]       analogRefFilterTc,
    input  wire logic [15:0]       applicationConfigWord,
    input  wire logic [LIM_W-1:0]  motorMaxTorque,
    input  wire logic [1:0]        ctrlMode,
    input  wire logic [ADC_W-1:0]  analogRef,
    // Results
    output logic      [LIM_W-1:0]  fwdTorqueLimit,
    output logic      [LIM_W-1:0]  revTorqueLimit,
    output logic                   analogLimitActive
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lesser of two limits
    function automatic logic [LIM_W-1:0] minLim(input logic [LIM_W-1:0] a,
                                                input logic [LIM_W-1:0] b);
        minLim = (a < b) ? a : b;
    endfunction : minLim

    // Clamp a setting into 0..800 %
    function automatic logic [LIM_W-1:0] clampPct(input logic [LIM_W-1:0] v);
        clampPct = (v > LIM_W'(tls_pkg::INT_LIMIT_MAX)) ? LIM_W'(tls_pkg::INT_LIMIT_MAX) : v;
    endfunction : clampPct

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and restart-latched mode

    logic [1:0] fwdSyncReg, fwdSyncNext;
    logic [1:0] revSyncReg, revSyncNext;
    logic       analogSelReg, analogSelNext;
    logic       cfgTakenReg,  cfgTakenNext;

    // Two-stage synchroniser per contact; only the second stage is read downstream
    always_comb begin
        fwdSyncNext   = {fwdSyncReg[0], ~fwdExtLimitIn_n};
        revSyncNext   = {revSyncReg[0], ~revExtLimitIn_n};
        cfgTakenNext  = 1'b1;
        analogSelNext = analogSelReg;
        if (!cfgTakenReg) begin
            // Selection caught once after reset release only
            analogSelNext = (applicationConfigWord[3:0] == tls_pkg::APP_ANALOG_LIMIT);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fwdSyncReg   <= 2'h0;
            revSyncReg   <= 2'h0;
            analogSelReg <= 1'b0;
            cfgTakenReg  <= 1'b0;
        end else begin
            fwdSyncReg   <= fwdSyncNext;
            revSyncReg   <= revSyncNext;
            analogSelReg <= analogSelNext;
            cfgTakenReg  <= cfgTakenNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog path: magnitude, filter, scaling

    logic [ADC_W-1:0] absRef;
    logic [ADC_W-1:0] filtRef;
    logic [6:0]       gainClamped;
    logic [31:0]      analogPct;
    logic [LIM_W-1:0] analogLimit;

    // Sign dropped: one magnitude serves both directions
    assign absRef = analogRef[ADC_W-1] ? ADC_W'(-analogRef) : analogRef;

    tls_analog_filter #(
        .ADC_W (ADC_W)
    ) u_filter (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .sampleMag (absRef),
        .timeConst (analogRefFilterTc),
        .filtered  (filtRef)
    );

    // Gain held inside 10..100; percent = mV * 100 / (gain * 100 mV)
    always_comb begin
        gainClamped = analogRefGain;
        if (analogRefGain < tls_pkg::GAIN_MIN) begin
            gainClamped = tls_pkg::GAIN_MIN;
        end else if (analogRefGain > tls_pkg::GAIN_MAX) begin
            gainClamped = tls_pkg::GAIN_MAX;
        end
        analogPct = 32'(filtRef) / 32'(gainClamped);
        if (analogPct > 32'(tls_pkg::INT_LIMIT_MAX)) begin
            analogLimit = LIM_W'(tls_pkg::INT_LIMIT_MAX);
        end else begin
            analogLimit = LIM_W'(analogPct);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit selection

    logic [LIM_W-1:0] fwdReg,  fwdNext;
    logic [LIM_W-1:0] revReg,  revNext;
    logic             anaActReg, anaActNext;
    logic             analogOn;

    // Analog limit only outside torque control
    assign analogOn = analogSelReg
                   && (ctrlMode != 2'(tls_pkg::TLS_MODE_TORQUE));

    // Smallest applicable limit per direction, then the motor ceiling
    always_comb begin
        fwdNext = clampPct(fwdInternalLimit);
        revNext = clampPct(revInternalLimit);
        if (fwdSyncReg[1]) begin
            fwdNext = minLim(fwdNext, clampPct(fwdExternalLimit));
        end
        if (revSyncReg[1]) begin
            revNext = minLim(revNext, clampPct(revExternalLimit));
        end
        if (analogOn) begin
            fwdNext = minLim(fwdNext, analogLimit);
            revNext = minLim(revNext, analogLimit);
        end
        fwdNext    = minLim(fwdNext, motorMaxTorque);
        revNext    = minLim(revNext, motorMaxTorque);
        anaActNext = analogOn;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fwdReg    <= '0;
            revReg    <= '0;
            anaActReg <= 1'b0;
        end else begin
            fwdReg    <= fwdNext;
            revReg    <= revNext;
            anaActReg <= anaActNext;
        end
    end

    assign fwdTorqueLimit    = fwdReg;
    assign revTorqueLimit    = revReg;
    assign analogLimitActive = anaActReg;

endmodule : tls_torque_limit_selector

`default_nettype wire

// ### verification/test_torque_limit_selector.sv
/* Self-checking bench for the torque limit selector.
   Drives settings at random with a fixed seed; host model moves contacts. */
`timescale 1ns/100ps
`default_nettype none
module test_torque_limit_selector;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        wantFwd = 1'b0;
    logic        wantRev = 1'b0;
    logic        anaSel  = 1'b0;
    logic        fwdExtLimitIn_n, revExtLimitIn_n, analogLimitActive;
    logic [9:0]  fwdInternalLimit = 10'h320, revInternalLimit = 10'h320;
    logic [9:0]  fwdExternalLimit = 10'h064, revExternalLimit = 10'h064;
    logic [9:0]  motorMaxTorque = 10'h3FF, fwdTorqueLimit, revTorqueLimit;
    logic [6:0]  analogRefGain = 7'h1E;
    logic [15:0] analogRefFilterTc = 16'h0000, applicationConfigWord = 16'h0000;
    logic [15:0] analogRef = 16'h0000;
    logic [1:0]  ctrlMode = 2'h0;
    int          fails = 0, n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    tls_torque_limit_selector dut (.*);
    tls_host_model host (.*);
    ////////////////////////////////////////////////////////////////
    // Expected limit of one direction
    function automatic logic [9:0] want(logic [9:0] in, logic [9:0] ex, logic on, logic an);
        int m;
        logic [9:0] v;
        m = $signed(analogRef);
        m = (m < 0) ? -m : m;
        m = m / analogRefGain;
        v = (in < 10'h320) ? in : 10'h320;
        v = (v < motorMaxTorque) ? v : motorMaxTorque;
        if (on && ex < v) v = ex;
        if (an && m < v) v = 10'(m);
        return v;
    endfunction : want
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %0d, expected %0d", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : tick
    // Waits, then compares both limits and the analog flag
    task automatic check(input int n);
        logic an;
        tick(n);
        an = anaSel && ctrlMode != 2'h2;
        chk(fwdTorqueLimit, want(fwdInternalLimit, fwdExternalLimit, wantFwd, an));
        chk(revTorqueLimit, want(revInternalLimit, revExternalLimit, wantRev, an));
        chk({9'h000, analogLimitActive}, {9'h000, an});
        $display("test done at %0t", $time);
    endtask : check
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////
    // Digital limits, then analog limiting after a second reset
    initial begin
        void'($urandom(43));
        tick(5);
        reset_n = 1'b1;
        check(3);
        fwdInternalLimit = 10'h3FF;
        revExternalLimit = 10'h000;
        wantRev = 1'b1;
        check(4);
        repeat (40) begin
            fwdInternalLimit = 10'($urandom_range(900));
            revInternalLimit = 10'($urandom_range(900));
            fwdExternalLimit = 10'($urandom_range(900));
            revExternalLimit = 10'($urandom_range(900));
            motorMaxTorque = 10'($urandom_range(1023));
            {wantFwd, wantRev} = 2'($urandom);
            check(4);
        end
        {wantFwd, wantRev, anaSel} = 3'h1;
        {fwdInternalLimit, revInternalLimit, motorMaxTorque} = {10'h320, 10'h320, 10'h3FF};
        applicationConfigWord = 16'h0001;
        analogRefFilterTc = 16'h0032;
        analogRef = 16'hEC78;
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        tick(150);
        chk(10'(fwdTorqueLimit < want(10'h320, 10'h000, 1'b0, 1'b1)), 10'h001);
        $display("test done at %0t", $time);
        analogRefFilterTc = 16'h0000;
        applicationConfigWord = 16'h0000;
        repeat (10) begin
            analogRef = 16'($urandom_range(20000)) - 16'h2710;
            analogRefGain = 7'($urandom_range(100, 10));
            ctrlMode = 2'($urandom_range(2));
            fwdInternalLimit = 10'($urandom_range(800));
            check(120);
        end
        results();
    end
    initial begin
        #2000000;
        fails++;
        results();
    end
endmodule : test_torque_limit_selector
bind tls_torque_limit_selector tls_checker chk_u (.*);
`default_nettype wire

// ### verification/tls_checker_asserts.sv
/* Port checker for the torque limit selector.
   Bound to the top module from the bench; one clock, async low reset. */
`timescale 1ns/100ps
`default_nettype none
module tls_checker (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        fwdExtLimitIn_n,
    input wire logic        revExtLimitIn_n,
    input wire logic [9:0]  fwdInternalLimit,
    input wire logic [9:0]  revInternalLimit,
    input wire logic [9:0]  fwdExternalLimit,
    input wire logic [9:0]  revExternalLimit,
    input wire logic [15:0] applicationConfigWord,
    input wire logic [9:0]  motorMaxTorque,
    input wire logic [1:0]  ctrlMode,
    input wire logic [9:0]  fwdTorqueLimit,
    input wire logic [9:0]  revTorqueLimit,
    input wire logic        analogLimitActive
);
    logic armed_reg;
    logic sel_reg;
    function automatic logic [9:0] lo(input logic [9:0] a, input logic [9:0] b);
        return (a < b) ? a : b;
    endfunction : lo
    // Mode digit as captured at the first edge after reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
            sel_reg   <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
            sel_reg   <= armed_reg ? sel_reg : (applicationConfigWord[3:0] == 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_cap;
        1'b1 |=> fwdTorqueLimit <= $past(motorMaxTorque) && revTorqueLimit <= $past(motorMaxTorque);
    endproperty
    a_cap: assert property (p_cap) else $error("limit above motor maximum");
    property p_int;
        1'b1 |=> fwdTorqueLimit <= $past(fwdInternalLimit) && revTorqueLimit <= $past(revInternalLimit);
    endproperty
    a_int: assert property (p_int) else $error("limit above internal setting");
    property p_idle;
        fwdExtLimitIn_n [*3] |=> !analogLimitActive |->
            fwdTorqueLimit == lo(lo($past(fwdInternalLimit), 10'h320), $past(motorMaxTorque));
    endproperty
    a_idle: assert property (p_idle) else $error("idle forward limit wrong");
    property p_fwd;
        !fwdExtLimitIn_n [*3] |=> fwdTorqueLimit <= $past(fwdExternalLimit);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward external limit ignored");
    sequence s_revOn;
        !revExtLimitIn_n [*3];
    endsequence
    property p_rev;
        s_revOn |=> revTorqueLimit <= $past(revInternalLimit)
            && revTorqueLimit <= $past(revExternalLimit);
    endproperty
    a_rev: assert property (p_rev) else $error("reverse limit above a setting");
    property p_sym;
        (fwdExtLimitIn_n && revExtLimitIn_n && fwdInternalLimit == revInternalLimit) [*3]
            |=> fwdTorqueLimit == revTorqueLimit;
    endproperty
    a_sym: assert property (p_sym) else $error("directions differ");
    property p_sel;
        armed_reg && !sel_reg |-> !analogLimitActive;
    endproperty
    a_sel: assert property (p_sel) else $error("analog on without selection");
    property p_torq;
        ctrlMode == 2'h2 |=> !analogLimitActive;
    endproperty
    a_torq: assert property (p_torq) else $error("analog on in torque mode");
    property p_on;
        armed_reg && sel_reg && ctrlMode != 2'h2 |=> analogLimitActive;
    endproperty
    a_on: assert property (p_on) else $error("analog limit not applied");
    c_ext: cover property (!fwdExtLimitIn_n [*3]);
    c_ana: cover property (analogLimitActive);
    c_torq: cover property (sel_reg && ctrlMode == 2'h2);
endmodule : tls_checker
`default_nettype wire

// ### verification/tls_host_model.sv
/* Host controller model driving the two limit contacts.
   Contacts move shortly after each rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module tls_host_model (
    input  wire logic clk_sys,
    input  wire logic wantFwd,
    input  wire logic wantRev,
    output logic      fwdExtLimitIn_n,
    output logic      revExtLimitIn_n
);
    ////////////////////////////////////////////////////////////////
    // Contacts open until a reduced ceiling is asked for
    initial {fwdExtLimitIn_n, revExtLimitIn_n} = 2'h3;
    always @(posedge clk_sys) begin
        fwdExtLimitIn_n <= #10 !wantFwd;
        revExtLimitIn_n <= #10 !wantRev;
    end
endmodule : tls_host_model
`default_nettype wire
